// *** asq_adc_seq.sv ***
// adc sampling, conversion sequencing and dma pacing control
`timescale 1ns/100ps
// Notes on behaviour
// - simultaneous sample one, two or four channels
// - simultaneous bit reads zero in 12-bit
// - auto start resamples after conversion ends
// - sample bit high while tracking
// - software or hardware trigger ends sampling
// - done flag set at end, cleared at start
// - software clears done only; no side effect
// - reference field selects supply or external
// - scan enable steps channel-0 input
// - channel count picks channels converted
// - channel count reads zero in 12-bit
// - buffer half bit shows filling half
// - increment every value-plus-one operations
// - split mode alternates fill start halves
// - alternate mode toggles sample a/b
// - clock source bit picks rc or divider
// - auto sample time in conversion clocks
// - sample time used only for counter trigger
// - divider gives period of value+1 cycles; values of 64 and up stop the clock
// - divider ignored when rc clock chosen
// - dma length gives two-power words per input
// - trigger code picks conversion start event
// - resolution bit selects 12-bit single channel
// - converter on bit enables the module
module asq_adc_seq #(
	parameter int CONV_TAD = 12
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              i_rc_tick,
	input  wire logic              i_trig_pin,
	input  wire logic              i_trig_tmr_a,
	input  wire logic              i_trig_tmr_b,
	output asq_pkg::asq_seq_s      o_seq,
	output logic                   o_sampling,
	output logic                   o_conv_start,
	output logic                   o_dma_req,
	output logic [7:0]             o_dma_words
);
	import asq_pkg::*;

	logic [15:0] ctrl1_reg, ctrl2_reg, ctrl3_reg, ctrl4_reg;
	logic        sample_active_reg, done_reg, buffer_half_status_reg, alt_reg;
	logic [7:0]  div_cnt_reg;
	logic        tad_tick_reg;
	logic [4:0]  samc_cnt_reg;
	logic [4:0]  tad_cnt_reg;
	logic [3:0]  smpi_cnt_reg;
	logic [1:0]  seq_cnt_reg;
	asq_state_e  state_reg;

	logic       on, res12, simultaneous_sample_sel, auto_start, wr, rd, sw_set, sw_clr, trig_hit;
	logic [2:0] trig;
	logic [1:0] chcnt;
	logic [7:0] div;
	logic       conv_end;

	// read value of a register, with reserved bits forced low
	function automatic logic [15:0] rd_mux(input logic [11:0] a);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			ASQ_OFF_CTRL1: begin
				v = ctrl1_reg & ASQ_MASK_CTRL1;
				v[ASQ_B_SIMULTANEOUS_SAMPLE_SEL] = simultaneous_sample_sel;
				v[ASQ_B_SAMPLE_ACTIVE] = sample_active_reg;
				v[ASQ_B_DONE] = done_reg;
			end
			ASQ_OFF_CTRL2: begin
				v = ctrl2_reg & ASQ_MASK_CTRL2;
				v[ASQ_B_CHCNT +: 2] = chcnt;
				v[ASQ_B_BUFFER_HALF_STATUS] = buffer_half_status_reg & ctrl2_reg[ASQ_B_BUFFER_SPLIT_MODE];
			end
			ASQ_OFF_CTRL3: v = ctrl3_reg & ASQ_MASK_CTRL3;
			ASQ_OFF_CTRL4: v = ctrl4_reg & ASQ_MASK_CTRL4;
			default:       v = 16'h0000;
		endcase
		return v;
	endfunction : rd_mux

	assign on         = ctrl1_reg[ASQ_B_ON];
	assign res12      = ctrl1_reg[ASQ_B_RES12];
	assign simultaneous_sample_sel     = ctrl1_reg[ASQ_B_SIMULTANEOUS_SAMPLE_SEL] & ~res12;
	assign auto_start = ctrl1_reg[ASQ_B_AUTO];
	assign trig       = ctrl1_reg[ASQ_B_TRIG_LO +: 3];
	assign chcnt      = res12 ? 2'h0 : ctrl2_reg[ASQ_B_CHCNT +: 2];
	assign div        = ctrl3_reg[7:0];
	assign wr         = psel & penable & pwrite;
	assign rd         = psel & penable & ~pwrite;
	assign sw_set     = wr && paddr == ASQ_OFF_CTRL1 && pwdata[ASQ_B_SAMPLE_ACTIVE];
	assign sw_clr     = wr && paddr == ASQ_OFF_CTRL1 && !pwdata[ASQ_B_SAMPLE_ACTIVE];
	assign conv_end   = state_reg == ASQ_CONVERT && tad_tick_reg && tad_cnt_reg == 5'h00;

	// trigger decode; reserved codes never fire
	always_comb begin
		unique case (trig)
			ASQ_TRIG_SW:   trig_hit = sw_clr;
			ASQ_TRIG_PIN:  trig_hit = i_trig_pin;
			ASQ_TRIG_TMRA: trig_hit = i_trig_tmr_a;
			ASQ_TRIG_TMRB: trig_hit = i_trig_tmr_b;
			ASQ_TRIG_AUTO: trig_hit = tad_tick_reg && samc_cnt_reg == 5'h00;
			default:       trig_hit = 1'b0;
		endcase
	end

	// apb slave: zero wait, error on unmapped
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > ASQ_OFF_CTRL4 || paddr[1:0] != 2'h0);
			prdata  <= (psel & ~penable & ~pwrite) ? {16'h0000, rd_mux(paddr)} : prdata;
		end
	end

	// control registers, taken when pready is seen high
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl1_reg <= ASQ_RST_CTRL;
			ctrl2_reg <= ASQ_RST_CTRL;
			ctrl3_reg <= ASQ_RST_CTRL;
			ctrl4_reg <= ASQ_RST_CTRL;
		end else if (wr && pready) begin
			unique case (paddr)
				ASQ_OFF_CTRL1: ctrl1_reg <= pwdata[15:0] & ASQ_MASK_CTRL1;
				ASQ_OFF_CTRL2: ctrl2_reg <= pwdata[15:0] & ASQ_MASK_CTRL2;
				ASQ_OFF_CTRL3: ctrl3_reg <= pwdata[15:0] & ASQ_MASK_CTRL3;
				ASQ_OFF_CTRL4: ctrl4_reg <= pwdata[15:0] & ASQ_MASK_CTRL4;
				default:       ctrl1_reg <= ctrl1_reg;
			endcase
		end
	end

	// conversion clock: rc tick or system clock divided by value+1, no ticks for values of 64 and up
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_cnt_reg  <= 8'h00;
			tad_tick_reg <= 1'b0;
		end else if (ctrl3_reg[ASQ_B_RCSEL]) begin
			div_cnt_reg  <= 8'h00;
			tad_tick_reg <= i_rc_tick;
		end else if (div_cnt_reg >= div || div >= ASQ_DIV_LIMIT) begin
			div_cnt_reg  <= 8'h00;
			tad_tick_reg <= div < ASQ_DIV_LIMIT;
		end else begin
			div_cnt_reg  <= div_cnt_reg + 8'h01;
			tad_tick_reg <= 1'b0;
		end
	end

	// sample / convert sequencer
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg    <= ASQ_IDLE;
			sample_active_reg     <= 1'b0;
			samc_cnt_reg <= 5'h00;
			tad_cnt_reg  <= 5'h00;
			o_conv_start <= 1'b0;
		end else begin
			o_conv_start <= 1'b0;
			if (!on) begin
				state_reg <= ASQ_IDLE;
				sample_active_reg  <= 1'b0;
			end else begin
				unique case (state_reg)
					ASQ_IDLE: if (auto_start || sw_set) begin
						state_reg    <= ASQ_SAMPLE;
						sample_active_reg     <= 1'b1;
						samc_cnt_reg <= ctrl3_reg[ASQ_B_SAMC_LO +: 5];
					end
					ASQ_SAMPLE: begin
						if (tad_tick_reg && samc_cnt_reg != 5'h00)
							samc_cnt_reg <= samc_cnt_reg - 5'h01;
						if (trig_hit) begin
							state_reg    <= ASQ_CONVERT;
							sample_active_reg     <= 1'b0;
							o_conv_start <= 1'b1;
							tad_cnt_reg  <= 5'(CONV_TAD - 1);
						end
					end
					ASQ_CONVERT: begin
						if (tad_tick_reg && tad_cnt_reg != 5'h00)
							tad_cnt_reg <= tad_cnt_reg - 5'h01;
						if (conv_end) begin
							state_reg    <= auto_start ? ASQ_SAMPLE : ASQ_IDLE;
							sample_active_reg     <= auto_start;
							samc_cnt_reg <= ctrl3_reg[ASQ_B_SAMC_LO +: 5];
						end
					end
				endcase
			end
		end
	end

	// done flag: hardware set wins over software clear
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			done_reg <= 1'b0;
		else if (conv_end)
			done_reg <= 1'b1;
		else if (o_conv_start)
			done_reg <= 1'b0;
		else if (wr && pready && paddr == ASQ_OFF_CTRL1 && !pwdata[ASQ_B_DONE])
			done_reg <= 1'b0;
	end

	// channel walk, dma pacing, buffer halves, alternate inputs
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			seq_cnt_reg  <= 2'h0;
			smpi_cnt_reg <= 4'h0;
			buffer_half_status_reg     <= 1'b0;
			alt_reg      <= 1'b0;
			o_dma_req    <= 1'b0;
		end else begin
			o_dma_req <= 1'b0;
			if (!ctrl2_reg[ASQ_B_BUFFER_SPLIT_MODE])
				buffer_half_status_reg <= 1'b0;
			if (conv_end) begin
				// sequential mode converts channels one at a time
				if (!simultaneous_sample_sel && seq_cnt_reg < chcnt_last(chcnt))
					seq_cnt_reg <= seq_cnt_reg + 2'h1;
				else begin
					seq_cnt_reg <= 2'h0;
					alt_reg     <= ctrl2_reg[ASQ_B_ALTERNATE_INPUT_MODE] & ~alt_reg;
					if (smpi_cnt_reg >= ctrl2_reg[ASQ_B_SMPI_LO +: 4]) begin
						smpi_cnt_reg <= 4'h0;
						o_dma_req    <= 1'b1;
						buffer_half_status_reg     <= ctrl2_reg[ASQ_B_BUFFER_SPLIT_MODE] & ~buffer_half_status_reg;
					end else
						smpi_cnt_reg <= smpi_cnt_reg + 4'h1;
				end
			end
		end
	end

	// last channel index for a channel-count code
	function automatic logic [1:0] chcnt_last(input logic [1:0] c);
		return c[1] ? 2'h3 : (c[0] ? 2'h1 : 2'h0);
	endfunction : chcnt_last

	// analog-side view, registered
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_seq       <= '0;
			o_sampling  <= 1'b0;
			o_dma_words <= 8'h01;
		end else begin
			o_sampling         <= sample_active_reg;
			o_seq.simultaneous <= simultaneous_sample_sel;
			o_seq.ch_mask      <= simultaneous_sample_sel ? 4'((1 << (3'(chcnt_last(chcnt)) + 3'h1)) - 1)
				: 4'(1 << seq_cnt_reg);
			o_seq.use_sample_b <= alt_reg;
			o_seq.scan_ch0     <= ctrl2_reg[ASQ_B_SCAN] & ~alt_reg;
			o_seq.clk_from_rc  <= ctrl3_reg[ASQ_B_RCSEL];
			o_seq.vref         <= ctrl2_reg[ASQ_B_VREF_LO + 2] ? ASQ_VREF_SUPPLY
				: asq_vref_e'(ctrl2_reg[ASQ_B_VREF_LO +: 2]);
			o_dma_words        <= 8'(1 << ctrl4_reg[2:0]);
		end
	end
endmodule : asq_adc_seq

// *** asq_adc_seq_asserts.sv ***
// concurrent checks on the adc sequencer control ports
`timescale 1ns/100ps
module asq_adc_seq_chk (
	input wire logic              i_sys_clk,
	input wire logic              i_sys_rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              o_sampling,
	input wire logic              o_conv_start,
	input wire logic              o_dma_req,
	input wire logic [7:0]        o_dma_words
);
	import asq_pkg::*;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	apb_once_a: assert property (pready |=> !pready)
		else $error("answer held too long");
	apb_refuse_a: assert property (psel && !penable && (paddr > 12'h00c || paddr[1:0] != 2'h0)
		|=> pslverr) else $error("bad address not refused");
	err_qual_a: assert property (pslverr |-> pready) else $error("error without answer");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	dma_words_a: assert property ($onehot(o_dma_words)) else $error("buffer length not power");
	conv_pulse_a: assert property (o_conv_start |=> !o_conv_start)
		else $error("conversion start held");
	dma_pulse_a: assert property (o_dma_req |=> !o_dma_req) else $error("dma request held");
	conv_after_a: assert property (o_conv_start |-> o_sampling)
		else $error("conversion without sampling");
	conv_c: cover property (o_conv_start);
	dma_c: cover property (o_dma_req);
	err_c: cover property (pslverr);
endmodule : asq_adc_seq_chk

// *** asq_adc_seq_tb.sv ***
// testbench for the adc sequencer control block
`timescale 1ns/100ps
module asq_adc_seq_tb;
	import asq_pkg::*;
	logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, rc, o_sampling, o_conv_start, o_dma_req;
	logic [2:0]  fire = 3'h0, trig;
	logic [7:0]  o_dma_words;
	logic [15:0] r1, r2, r3, r4;
	logic [2:0]  tc[3] = '{3'h1, 3'h2, 3'h4};
	asq_seq_s    o_seq;
	logic [33:0] aq[$];
	int          dq[$];
	int          failures = 0, n_tests = 0, n_conv = 0, t;
	asq_adc_seq #(.CONV_TAD(2)) u_asq_adc_seq (.i_sys_clk, .i_sys_rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .i_rc_tick(rc), .i_trig_pin(trig[0]),
		.i_trig_tmr_a(trig[1]), .i_trig_tmr_b(trig[2]), .o_seq, .o_sampling, .o_conv_start,
		.o_dma_req, .o_dma_words);
	asq_far_model u_asq_far_model (.i_sys_clk, .i_sys_rst, .i_fire(fire), .o_rc_tick(rc),
		.o_trig(trig));
	initial begin
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		if (failures == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
		input logic [33:0] e);
		int k;
		@(posedge i_sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		aq.push_back(e);
		@(posedge i_sys_clk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge i_sys_clk);
		if (k == 20) begin
			failures++;
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic err);
		apb(1'b1, a, d, {1'b0, err, 32'h0});
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [15:0] d);
		apb(1'b0, a, 16'h0, {2'b10, 16'h0, d});
	endtask : rd
	// waits until n conversions started and every noted dma request arrived
	task automatic wait_for(input int n);
		int k;
		for (k = 0; k < 500 && (n_conv < n || dq.size() > 0); k++) @(posedge i_sys_clk);
		if (k == 500) begin
			failures++;
			end_sim();
		end
	endtask : wait_for
	always @(posedge i_sys_clk) begin
		logic [33:0] e;
		if (o_conv_start === 1'b1) n_conv++;
		if (o_dma_req === 1'b1) chk(n_conv, dq.size() > 0 ? dq.pop_front() : -1);
		if (psel && penable && pready === 1'b1) begin
			e = aq.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) chk(prdata, e[31:0]);
		end
	end
	initial begin
		void'($urandom(32'hfde6));
		repeat (16) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) rd(12'(i * 4), ASQ_RST_CTRL);
		repeat (4) begin
			r1 = 16'($urandom()) & 16'h04ec;
			r2 = 16'($urandom());
			r3 = 16'($urandom());
			r4 = 16'($urandom());
			wr(ASQ_OFF_CTRL1, r1, 1'b0);
			wr(ASQ_OFF_CTRL2, r2, 1'b0);
			wr(ASQ_OFF_CTRL3, r3, 1'b0);
			wr(ASQ_OFF_CTRL4, r4, 1'b0);
			rd(ASQ_OFF_CTRL1, r1 & (r1[10] ? 16'hfff7 : 16'hffff));
			rd(ASQ_OFF_CTRL2, r2 & ASQ_MASK_CTRL2 & (r1[10] ? 16'hfcff : 16'hffff));
			rd(ASQ_OFF_CTRL3, r3 & ASQ_MASK_CTRL3);
			rd(ASQ_OFF_CTRL4, r4 & ASQ_MASK_CTRL4);
			chk(o_dma_words, 32'h1 << r4[2:0]);
			chk(o_seq.vref, r2[15] ? 2'h0 : r2[14:13]);
			chk(o_seq.clk_from_rc, r3[15]);
		end
		apb(1'b0, 12'h010, 16'h0, {2'b11, 32'h0});
		wr(12'h002, 16'hffff, 1'b1);
		wr(ASQ_OFF_CTRL3, 16'h0000, 1'b0);
		wr(ASQ_OFF_CTRL2, 16'h0000, 1'b0);
		wr(ASQ_OFF_CTRL1, 16'h8000, 1'b0);
		wr(ASQ_OFF_CTRL1, 16'h8002, 1'b0);
		repeat (3) @(posedge i_sys_clk);
		chk(o_sampling, 1'b1);
		dq.push_back(1);
		wr(ASQ_OFF_CTRL1, 16'h8000, 1'b0);
		wait_for(1);
		rd(ASQ_OFF_CTRL1, 16'h8001);
		wr(ASQ_OFF_CTRL1, 16'h8000, 1'b0);
		rd(ASQ_OFF_CTRL1, 16'h8000);
		foreach (tc[i]) begin
			wr(ASQ_OFF_CTRL1, 16'h8002 | (16'(tc[i]) << 5), 1'b0);
			t = n_conv + 1;
			dq.push_back(t);
			repeat (3) @(posedge i_sys_clk);
			fire <= tc[i];
			@(posedge i_sys_clk);
			fire <= 3'h0;
			wait_for(t);
			rd(ASQ_OFF_CTRL1, 16'h8001 | (16'(tc[i]) << 5));
		end
		wr(ASQ_OFF_CTRL1, 16'h8008, 1'b0);
		wr(ASQ_OFF_CTRL2, 16'h0200, 1'b0);
		repeat (3) @(posedge i_sys_clk);
		chk(o_seq.ch_mask, 32'hf);
		wr(ASQ_OFF_CTRL2, 16'h0100, 1'b0);
		repeat (3) @(posedge i_sys_clk);
		chk(o_seq.ch_mask, 32'h3);
		wr(ASQ_OFF_CTRL3, 16'h0200, 1'b0);
		wr(ASQ_OFF_CTRL2, 16'h0004, 1'b0);
		t = n_conv + 4;
		dq.push_back(t - 2);
		dq.push_back(t);
		wr(ASQ_OFF_CTRL1, 16'h80e6, 1'b0);
		wait_for(t);
		wr(ASQ_OFF_CTRL1, 16'h0000, 1'b0);
		repeat (3) @(posedge i_sys_clk);
		chk(o_sampling, 1'b0);
		end_sim();
	end
endmodule : asq_adc_seq_tb
bind asq_adc_seq asq_adc_seq_chk u_asq_adc_seq_chk (.i_sys_clk, .i_sys_rst, .psel, .penable,
	.paddr, .prdata, .pready, .pslverr, .o_sampling, .o_conv_start, .o_dma_req, .o_dma_words);

// *** asq_far_model.sv ***
// far side model: rc conversion clock ticks and trigger sources
`timescale 1ns/100ps
module asq_far_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_sys_rst,
	input  wire logic [2:0] i_fire,
	output logic            o_rc_tick,
	output logic [2:0]      o_trig
);
	logic [1:0] tick_reg;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tick_reg <= 2'h0;
			o_rc_tick <= 1'b0;
		end else begin
			tick_reg <= tick_reg + 2'h1;
			o_rc_tick <= (tick_reg == 2'h3);
		end
	end
	// one-cycle pulses: bit 0 pin, bit 1 timer a, bit 2 timer b
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) o_trig <= 3'h0;
		else o_trig <= i_fire;
	end
endmodule : asq_far_model

// *** asq_pkg.sv ***
// package for the adc sequencer control block
package asq_pkg;
	// register byte offsets
	localparam logic [11:0] ASQ_OFF_CTRL1 = 12'h000;
	localparam logic [11:0] ASQ_OFF_CTRL2 = 12'h004;
	localparam logic [11:0] ASQ_OFF_CTRL3 = 12'h008;
	localparam logic [11:0] ASQ_OFF_CTRL4 = 12'h00c;

	// control one fields
	localparam int ASQ_B_ON      = 15;
	localparam int ASQ_B_RES12   = 10;
	localparam int ASQ_B_TRIG_LO = 5;
	localparam int ASQ_B_SIMULTANEOUS_SAMPLE_SEL  = 3;
	localparam int ASQ_B_AUTO    = 2;
	localparam int ASQ_B_SAMPLE_ACTIVE    = 1;
	localparam int ASQ_B_DONE    = 0;
	// control two fields
	localparam int ASQ_B_VREF_LO = 13;
	localparam int ASQ_B_SCAN    = 10;
	localparam int ASQ_B_CHCNT   = 8;
	localparam int ASQ_B_BUFFER_HALF_STATUS    = 7;
	localparam int ASQ_B_SMPI_LO = 2;
	localparam int ASQ_B_BUFFER_SPLIT_MODE    = 1;
	localparam int ASQ_B_ALTERNATE_INPUT_MODE    = 0;
	// control three fields
	localparam int ASQ_B_RCSEL   = 15;
	localparam int ASQ_B_SAMC_LO = 8;

	localparam logic [15:0] ASQ_MASK_CTRL1 = 16'h84ef;
	localparam logic [15:0] ASQ_MASK_CTRL2 = 16'he73f;
	localparam logic [15:0] ASQ_MASK_CTRL3 = 16'h9fff;
	localparam logic [15:0] ASQ_MASK_CTRL4 = 16'h0007;
	localparam logic [15:0] ASQ_RST_CTRL   = 16'h0000;

	localparam logic [2:0] ASQ_TRIG_SW    = 3'h0;
	localparam logic [2:0] ASQ_TRIG_PIN   = 3'h1;
	localparam logic [2:0] ASQ_TRIG_TMRA  = 3'h2;
	localparam logic [2:0] ASQ_TRIG_TMRB  = 3'h4;
	localparam logic [2:0] ASQ_TRIG_AUTO  = 3'h7;
	localparam logic [7:0] ASQ_DIV_LIMIT  = 8'h40;

	typedef enum logic [1:0] {
		ASQ_VREF_SUPPLY,
		ASQ_VREF_EXT_POS,
		ASQ_VREF_EXT_NEG,
		ASQ_VREF_EXT_BOTH
	} asq_vref_e;

	typedef enum {ASQ_IDLE, ASQ_SAMPLE, ASQ_CONVERT} asq_state_e;

	// view of the current sequence handed to the analog side
	typedef struct packed {
		logic [3:0] ch_mask;
		logic       simultaneous;
		logic       use_sample_b;
		logic       scan_ch0;
		asq_vref_e  vref;
		logic       clk_from_rc;
	} asq_seq_s;
endpackage : asq_pkg
